// File: rtl/slot_tx_pkg.sv
// Constants, types and register map of the sensor slot transmitter
// Behaviour
// - Selectable 16-bit resolution and daisy chain modes
// - 16-bit mode clips and scales filter output
// - Sample timing bit picks simultaneous or synchronous
// - Latch at sync rise or slot A offset
// - Send truncated top ten bits at slot A
// - Clip to 480 counts, low bits at slot B
// - Init data identical in slot A and B
// - Offset conflict suppresses slot B
// - Chain init answers in programming slot
// - After init phase 3, await set-address
// - Set-address reply in programming slot
// - Blank syncs after addressing, await run-mode
// - Run-mode: chain slot, fixed format, ignore commands
// - Chain mode keeps sync pulldown enabled
// - Set-address: target zero, address in function
// - Run-mode: target all ones, function zero
// - Reply code OK or error with number
// - Address picks switch state and chain slot
// - Offset error gives temporary defect messages
// - Self-test or integrity failure latches defect
// - Undervoltage halts transmissions until recovery
package slot_tx_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] SLOT_OFS   = 12'h004;
  localparam logic [11:0] INIT_OFS   = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  // Control fields
  localparam int MODE_LSB   = 0;
  localparam int SYNC_BIT   = 2;
  localparam int SLOTB_LSB  = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SLOT_RST = 32'h0000_0000;
  localparam logic [31:0] INIT_RST = 32'h0000_0000;
  // Modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_RES16  = 2'h2;
  localparam logic [1:0] MODE_CHAIN  = 2'h3;
  // Reply codes and command fields
  localparam logic [9:0] REPLY_OK   = 10'h1e1;
  localparam logic [9:0] REPLY_ERR  = 10'h1e2;
  localparam logic [2:0] ADDR_NONE  = 3'h0;
  localparam logic [2:0] ADDR_BCAST = 3'h7;
  localparam logic [2:0] ADDR_OPEN  = 3'h4;
  localparam logic [2:0] FUNC_RUN   = 3'h0;
  // Sample scaling
  localparam logic signed [15:0] CLIP_HI = 16'sd480;
  localparam logic signed [15:0] CLIP_LO = -16'sd480;
  // Timing: slot offsets count in half microseconds
  localparam int CLK_MHZ       = 40;
  localparam int SLOT_RES_NS   = 500;
  localparam int TICK_CYC      = SLOT_RES_NS * CLK_MHZ / 1000;
  localparam int TICK_W        = 5;

  typedef enum {ST_INIT, ST_WAIT_ADDR, ST_ADDR_REPLY, ST_BLANK,
                ST_WAIT_RUN, ST_RUN_REPLY, ST_RUN} chain_st_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [2:0] addr;
    logic [2:0] func;
    logic [9:0] error_number;
  } cmd_t;

  typedef struct packed {
    logic offset_err;
    logic selftest_fail;
    logic integrity_one_n;
    logic integrity_two_n;
    logic undervoltage;
  } fault_t;
endpackage

// File: rtl/sensor_slot_tx.sv
// Transmit slot scheduler with 16-bit split, daisy chain and error handling
//
// Chosen here: the placing of the registers and register access over APB.
module sensor_slot_tx import slot_tx_pkg::*; #(
  parameter logic [9:0]  CHAIN_PROG_SLOT  = 10'd100,
  parameter logic [9:0]  CHAIN_SLOT_ONE   = 10'd100,
  parameter logic [9:0]  CHAIN_SLOT_TWO   = 10'd200,
  parameter logic [9:0]  CHAIN_SLOT_THREE = 10'd300,
  parameter logic [9:0]  FRAME_TICKS      = 10'd104,
  parameter logic [9:0]  DEFECT_WORD      = 10'h1f0,
  parameter int          BLANK_CYC        = 40000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor and bus side
  input  wire logic        sync_pin,
  input  wire logic [25:0] filt_data,
  input  wire logic        init_active,
  input  wire logic        init_done,
  input  wire cmd_t        cmd,
  input  wire fault_t      fault_pin,
  // Transmit request
  output logic             tx_valid,
  output logic [9:0]       tx_data,
  output logic             tx_fixed_fmt,
  output logic             sync_pulldown_en,
  output logic             bus_switch_closed
);
  // Synchronisers
  logic   sync_m_q, sync_s_q, sync_p_q;
  fault_t fault_m_q, fault_s_q;
  localparam fault_t FAULT_IDLE = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_q  <= 1'b0;
      sync_s_q  <= 1'b0;
      sync_p_q  <= 1'b0;
      fault_m_q <= FAULT_IDLE;
      fault_s_q <= FAULT_IDLE;
    end else begin
      sync_m_q  <= sync_pin;
      sync_s_q  <= sync_m_q;
      sync_p_q  <= sync_s_q;
      fault_m_q <= fault_pin;
      fault_s_q <= fault_m_q;
    end
  end
  logic sync_rise;
  assign sync_rise = sync_s_q & ~sync_p_q;

  // APB registers
  logic [31:0] ctrl_q, ctrl_d, slot_q, slot_d, init_q, init_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] status;
  logic        hit;
  always_comb begin
    ctrl_d    = ctrl_q;
    slot_d    = slot_q;
    init_d    = init_q;
    prdata_d  = prdata_q;
    pready_d  = psel & ~penable;
    pslverr_d = 1'b0;
    hit       = paddr == CTRL_OFS || paddr == SLOT_OFS || paddr == INIT_OFS || paddr == STATUS_OFS;
    if (psel && !penable) begin
      pslverr_d = ~hit;
      case (paddr)
        CTRL_OFS:   prdata_d = ctrl_q;
        SLOT_OFS:   prdata_d = slot_q;
        INIT_OFS:   prdata_d = init_q;
        STATUS_OFS: prdata_d = status;
        default:    prdata_d = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pready_q && pwrite) begin
      case (paddr)
        CTRL_OFS: ctrl_d = {29'h0, pwdata[SYNC_BIT:0]};
        SLOT_OFS: slot_d = {6'h0, pwdata[SLOTB_LSB +: 10], 6'h0, pwdata[9:0]};
        INIT_OFS: init_d = {22'h0, pwdata[9:0]};
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RST;
      slot_q    <= SLOT_RST;
      init_q    <= INIT_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      slot_q    <= slot_d;
      init_q    <= init_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Configuration views
  logic [1:0] mode;
  logic       sync_sampling;
  logic [9:0] slot_a_offset, slot_b_offset;
  assign mode          = ctrl_q[MODE_LSB +: 2];
  assign sync_sampling = ctrl_q[SYNC_BIT];
  assign slot_a_offset = slot_q[9:0];
  assign slot_b_offset = slot_q[SLOTB_LSB +: 10];

  // Sample scaling
  logic [20:0]        rounded;
  logic signed [15:0] word16;
  logic               ovf;
  always_comb begin
    rounded = {filt_data[25], filt_data[25:6]} + {20'h0, filt_data[5]};
    ovf     = !((rounded[20:15] == 6'h00) || (rounded[20:15] == 6'h3f));
    if (ovf) begin
      word16 = filt_data[25] ? 16'sh8000 : 16'sh7fff;
    end else begin
      word16 = rounded[15:0];
    end
  end

  // Core state
  chain_st_t   st_q, st_d;
  logic [TICK_W-1:0] sub_q, sub_d;
  logic [9:0]  tick_q, tick_d;
  logic        frame_q, frame_d;
  logic [15:0] sample_q, sample_d, smp;
  logic [2:0]  addr_q, addr_d;
  logic [9:0]  rc_q, rc_d, rd_q, rd_d;
  logic        rphase_q, rphase_d;
  logic        ok_q, ok_d;
  logic        latched_q, latched_d;
  logic [31:0] blank_q, blank_d;
  logic        tx_valid_q, tx_valid_d;
  logic [9:0]  tx_data_q, tx_data_d;
  logic        fixed_q, fixed_d, pd_q, pd_d, sw_q, sw_d;
  logic [9:0]  chain_slot, a_word, b_word;
  logic        chain, defect, halt, conflict, at_a, at_b, at_chain, at_prog;

  assign status = {17'h0, latched_q, defect, halt, 6'h0, addr_q, 3'(st_q)};

  always_comb begin
    case (addr_q)
      3'h1, 3'h4: chain_slot = CHAIN_SLOT_ONE;
      3'h2, 3'h5: chain_slot = CHAIN_SLOT_TWO;
      3'h3, 3'h6: chain_slot = CHAIN_SLOT_THREE;
      default:    chain_slot = CHAIN_SLOT_ONE;
    endcase
  end

  always_comb begin
    chain    = mode == MODE_CHAIN;
    latched_d = latched_q | fault_s_q.selftest_fail | ~fault_s_q.integrity_one_n
                | ~fault_s_q.integrity_two_n;
    defect   = latched_q | fault_s_q.offset_err;
    halt     = fault_s_q.undervoltage;
    conflict = {1'b0, slot_b_offset} < {1'b0, slot_a_offset} + {1'b0, FRAME_TICKS};
    at_a     = frame_q && sub_q == '0 && tick_q == slot_a_offset;
    at_b     = frame_q && sub_q == '0 && tick_q == slot_b_offset;
    at_chain = frame_q && sub_q == '0 && tick_q == chain_slot;
    at_prog  = frame_q && sub_q == '0 && tick_q == CHAIN_PROG_SLOT;
    smp      = at_a && sync_sampling ? word16 : sample_q;
    if (init_active) begin
      a_word = init_q[9:0];
      b_word = init_q[9:0];
    end else if (defect) begin
      a_word = DEFECT_WORD;
      b_word = DEFECT_WORD;
    end else begin
      a_word = smp[15:6];
      b_word = smp[9:0];
    end
    st_d       = st_q;
    sub_d      = sub_q;
    tick_d     = tick_q;
    frame_d    = frame_q;
    sample_d   = sample_q;
    addr_d     = addr_q;
    rc_d       = rc_q;
    rd_d       = rd_q;
    rphase_d   = rphase_q;
    ok_d       = ok_q;
    blank_d    = blank_q;
    tx_valid_d = 1'b0;
    tx_data_d  = tx_data_q;
    fixed_d    = chain && (st_q == ST_RUN_REPLY || st_q == ST_RUN);
    pd_d       = chain;
    sw_d       = chain && addr_q != ADDR_NONE && addr_q < ADDR_OPEN;
    // Slot timebase from the sync rising edge
    if (frame_q) begin
      if (sub_q == 5'(TICK_CYC - 1)) begin
        sub_d  = '0;
        tick_d = tick_q + 10'h001;
        if (tick_q == 10'h3ff) begin
          frame_d = 1'b0;
        end
      end else begin
        sub_d = sub_q + 5'h01;
      end
    end
    if (sync_rise && st_q != ST_BLANK) begin
      frame_d = 1'b1;
      sub_d   = '0;
      tick_d  = '0;
      if (!sync_sampling) begin
        sample_d = word16;
      end
    end
    if (at_a && sync_sampling) begin
      sample_d = word16;
    end
    // Transmission per mode
    if (!chain) begin
      if (at_a && !halt) begin
        tx_valid_d = 1'b1;
        tx_data_d  = a_word;
      end
      if (at_b && !halt && !conflict && mode != MODE_NORMAL) begin
        tx_valid_d = 1'b1;
        tx_data_d  = mode == MODE_RES16 && !init_active && !defect ? clipped_b(sample_q) : b_word;
      end
    end else begin
      case (st_q)
        ST_INIT: begin
          if (at_prog && !halt) begin
            tx_valid_d = 1'b1;
            tx_data_d  = init_active ? init_q[9:0] : a_word;
          end
          if (init_done) begin
            st_d = ST_WAIT_ADDR;
          end
        end
        ST_WAIT_ADDR, ST_WAIT_RUN: begin
          if (cmd.valid) begin
            rphase_d = 1'b0;
            if (cmd.err) begin
              rc_d = REPLY_ERR;
              rd_d = cmd.error_number;
              ok_d = 1'b0;
              st_d = st_q == ST_WAIT_ADDR ? ST_ADDR_REPLY : ST_RUN_REPLY;
            end else if (st_q == ST_WAIT_ADDR && cmd.addr == ADDR_NONE
                         && cmd.func != ADDR_NONE && cmd.func != ADDR_BCAST) begin
              rc_d   = REPLY_OK;
              rd_d   = {7'h0, cmd.func};
              addr_d = cmd.func;
              ok_d   = 1'b1;
              st_d   = ST_ADDR_REPLY;
            end else if (st_q == ST_WAIT_RUN && cmd.addr == ADDR_BCAST && cmd.func == FUNC_RUN) begin
              rc_d = REPLY_OK;
              rd_d = 10'h000;
              ok_d = 1'b1;
              st_d = ST_RUN_REPLY;
            end
          end
        end
        ST_ADDR_REPLY: begin
          if (at_prog && !halt) begin
            tx_valid_d = 1'b1;
            tx_data_d  = rphase_q ? rd_q : rc_q;
            rphase_d   = 1'b1;
            if (rphase_q) begin
              st_d    = ok_q ? ST_BLANK : ST_WAIT_ADDR;
              blank_d = 32'(BLANK_CYC);
              frame_d = 1'b0;
            end
          end
        end
        ST_BLANK: begin
          if (blank_q == 32'h0) begin
            st_d = ST_WAIT_RUN;
          end else begin
            blank_d = blank_q - 32'h1;
          end
        end
        ST_RUN_REPLY: begin
          if (at_chain && !halt) begin
            tx_valid_d = 1'b1;
            tx_data_d  = rphase_q ? rd_q : rc_q;
            rphase_d   = 1'b1;
            if (rphase_q) begin
              st_d = ok_q ? ST_RUN : ST_WAIT_RUN;
            end
          end
        end
        ST_RUN: begin
          if (at_chain && !halt) begin
            tx_valid_d = 1'b1;
            tx_data_d  = a_word;
          end
        end
        default: st_d = ST_INIT;
      endcase
    end
  end

  function automatic logic [9:0] clipped_b(input logic [15:0] s);
    logic signed [15:0] v;
    v = s;
    if (v > CLIP_HI) begin
      v = CLIP_HI;
    end else if (v < CLIP_LO) begin
      v = CLIP_LO;
    end
    return v[9:0];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_INIT;
      sub_q      <= '0;
      tick_q     <= '0;
      frame_q    <= 1'b0;
      sample_q   <= '0;
      addr_q     <= ADDR_NONE;
      rc_q       <= '0;
      rd_q       <= '0;
      rphase_q   <= 1'b0;
      ok_q       <= 1'b0;
      latched_q  <= 1'b0;
      blank_q    <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
      fixed_q    <= 1'b0;
      pd_q       <= 1'b0;
      sw_q       <= 1'b0;
    end else begin
      st_q       <= st_d;
      sub_q      <= sub_d;
      tick_q     <= tick_d;
      frame_q    <= frame_d;
      sample_q   <= sample_d;
      addr_q     <= addr_d;
      rc_q       <= rc_d;
      rd_q       <= rd_d;
      rphase_q   <= rphase_d;
      ok_q       <= ok_d;
      latched_q  <= latched_d;
      blank_q    <= blank_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q  <= tx_data_d;
      fixed_q    <= fixed_d;
      pd_q       <= pd_d;
      sw_q       <= sw_d;
    end
  end
  assign tx_valid          = tx_valid_q;
  assign tx_data           = tx_data_q;
  assign tx_fixed_fmt      = fixed_q;
  assign sync_pulldown_en  = pd_q;
  assign bus_switch_closed = sw_q;
endmodule

// File: bench/slot_tx_checker.sv
// Assertions on the slot transmitter ports
module slot_tx_checker import slot_tx_pkg::*; (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // APB
  input wire logic   psel,
  input wire logic   penable,
  input wire logic   pready,
  input wire logic   pslverr,
  // Bus side
  input wire cmd_t   cmd,
  input wire fault_t fault_pin,
  input wire logic   tx_valid,
  input wire logic   tx_fixed_fmt,
  input wire logic   sync_pulldown_en,
  input wire logic   bus_switch_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_setup_ready: assert property (psel && !penable |-> !pready ##1 pready)
    else $error("Access phase without ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("Slave error without ready");
  a_tx_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("Transmit strobe held");
  a_uv_silent: assert property (fault_pin.undervoltage [*5] |-> !tx_valid)
    else $error("Transmit during undervoltage");
  a_run_pulldown: assert property (tx_fixed_fmt |-> sync_pulldown_en)
    else $error("Run format without pulldown");
  a_switch_chain: assert property (bus_switch_closed |-> sync_pulldown_en)
    else $error("Switch closed outside chain mode");
  a_run_ignore: assert property (tx_fixed_fmt && cmd.valid |=> tx_fixed_fmt && $stable(bus_switch_closed))
    else $error("Command acted on in run mode");
  c_run_tx: cover property (tx_fixed_fmt && tx_valid);
  c_slverr: cover property (pslverr);
  c_switch: cover property (bus_switch_closed && tx_valid);
endmodule

// File: bench/ecu_model.sv
// Control unit model: sync pulses and chain commands
module ecu_model import slot_tx_pkg::*; (
  // Clock
  input  wire logic pclk,
  // Bus side
  output logic      sync_pin,
  output cmd_t      cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sync_pin = 1'b0;
    cmd      = '0;
  end
  // Short sync pulse, idle low
  task automatic sync_pulse();
    sync_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    sync_pin <= 1'b0;
  endtask
  // One-cycle command, fields scrambled while idle
  task automatic send(input logic e, input logic [2:0] a, input logic [2:0] f, input logic [9:0] n);
    cmd <= {1'b1, e, a, f, n};
    @(posedge pclk);
    cmd <= {1'b0, ~e, ~a, ~f, ~n};
  endtask
  task automatic set_addr(input logic [2:0] a);
    send(1'b0, ADDR_NONE, a, 10'h000);
  endtask
  task automatic run_mode();
    send(1'b0, ADDR_BCAST, FUNC_RUN, 10'h000);
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the slot transmitter
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
module tb import slot_tx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] DW = 10'h1f0;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic        pready, pslverr, sync_pin, tx_valid, tx_fixed_fmt, sync_pulldown_en, bus_switch_closed, e;
  logic [25:0] filt_data = '0;
  logic        init_active = 1'b0, init_done = 1'b0;
  cmd_t        cmd;
  fault_t      fault_pin = 5'b00110;
  logic [9:0]  tx_data;
  int          bad_count = 0, total_checks = 0, cyc = 0, t0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  sensor_slot_tx #(.CHAIN_PROG_SLOT(10'd3), .CHAIN_SLOT_TWO(10'd5), .FRAME_TICKS(10'd8), .BLANK_CYC(20))
    DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_pin(sync_pin), .filt_data(filt_data), .init_active(init_active),
    .init_done(init_done), .cmd(cmd), .fault_pin(fault_pin), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_fixed_fmt(tx_fixed_fmt), .sync_pulldown_en(sync_pulldown_en), .bus_switch_closed(bus_switch_closed));
  ecu_model ecu (.pclk(pclk), .sync_pin(sync_pin), .cmd(cmd));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic sync();
    t0 = cyc;
    fork
      ecu.sync_pulse();
    join_none
  endtask
  // Next transmit after the last sync: word and offset in ticks
  task automatic nxt(input int ofs, input logic [9:0] x, input bit dc);
    int c;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (tx_valid !== 1'b1 && c < 3000);
    if (dc) `CHK(tx_data, x)
    `CHK((cyc - t0) inside {[ofs * 20 : ofs * 20 + 8]}, 1'b1)
  endtask
  task automatic frm(input int ofs, input logic [9:0] x);
    sync();
    nxt(ofs, x, 1'b1);
  endtask
  task automatic quiet(input bit s);
    int c;
    c = 0;
    if (s) sync();
    repeat (300) begin
      @(posedge pclk);
      if (tx_valid === 1'b1) c++;
    end
    `CHK(c, 0)
  endtask
  task automatic res16(input logic [25:0] f0, input logic [25:0] f1, input logic [9:0] xa, input logic [9:0] xb);
    filt_data <= f0;
    @(posedge pclk);
    sync();
    repeat (10) @(posedge pclk);
    filt_data <= f1;
    nxt(2, xa, 1'b1);
    nxt(12, xb, 1'b1);
  endtask
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(r, CTRL_RST)
    apb(1'b0, SLOT_OFS, 32'h0);
    `CHK(r, SLOT_RST)
    apb(1'b1, 12'h010, 32'h5);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({e, r}, 33'h100000000)
    apb(1'b1, CTRL_OFS, 32'h6);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(r, 32'h6)
    $display("registers done");
  endtask
  task automatic t_res16();
    apb(1'b1, SLOT_OFS, 32'h000c_0002);
    apb(1'b1, INIT_OFS, 32'h155);
    apb(1'b1, CTRL_OFS, 32'h2);
    init_active <= 1'b1;
    res16(26'h0, 26'h0, 10'h155, 10'h155);
    init_active <= 1'b0;
    res16(26'h0004030, 26'h3f80000, 10'h004, 10'h101);
    res16(26'h0800000, 26'h0800000, 10'h1ff, 10'h1e0);
    apb(1'b1, CTRL_OFS, 32'h6);
    res16(26'h0004030, 26'h3f80000, 10'h380, 10'h220);
    apb(1'b1, SLOT_OFS, 32'h0005_0002);
    frm(2, 10'h380);
    quiet(1'b0);
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, SLOT_OFS, 32'h000c_0002);
    res16(26'h0004030, 26'h0004030, 10'h004, 10'h101);
    $display("resolution mode done");
  endtask
  task automatic t_chain();
    rst();
    apb(1'b1, INIT_OFS, 32'h155);
    apb(1'b1, CTRL_OFS, 32'h3);
    init_active <= 1'b1;
    frm(3, 10'h155);
    `CHK(sync_pulldown_en, 1'b1)
    init_active <= 1'b0;
    init_done   <= 1'b1;
    @(posedge pclk);
    init_done   <= 1'b0;
    quiet(1'b1);
    ecu.send(1'b1, ADDR_NONE, 3'h0, 10'h2a5);
    frm(3, REPLY_ERR);
    frm(3, 10'h2a5);
    ecu.set_addr(3'h2);
    frm(3, REPLY_OK);
    frm(3, 10'h002);
    `CHK(bus_switch_closed, 1'b1)
    repeat (40) @(posedge pclk);
    quiet(1'b1);
    ecu.run_mode();
    frm(5, REPLY_OK);
    frm(5, 10'h000);
    `CHK(tx_fixed_fmt, 1'b1)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(r, 32'h0000_0016)
    ecu.set_addr(3'h5);
    sync();
    nxt(5, 10'h0, 1'b0);
    `CHK(bus_switch_closed, 1'b1)
    $display("chain mode done");
  endtask
  task automatic fcfg();
    rst();
    apb(1'b1, INIT_OFS, 32'h155);
    apb(1'b1, SLOT_OFS, 32'h2);
    filt_data <= 26'h0040000;
  endtask
  task automatic t_fault();
    fcfg();
    fault_pin.offset_err <= 1'b1;
    frm(2, DW);
    fault_pin.offset_err <= 1'b0;
    frm(2, 10'h040);
    fault_pin.undervoltage <= 1'b1;
    repeat (4) @(posedge pclk);
    quiet(1'b1);
    fault_pin.undervoltage <= 1'b0;
    frm(2, 10'h040);
    fault_pin.selftest_fail <= 1'b1;
    repeat (4) @(posedge pclk);
    fault_pin.selftest_fail <= 1'b0;
    frm(2, DW);
    fcfg();
    fault_pin.integrity_two_n <= 1'b0;
    repeat (4) @(posedge pclk);
    fault_pin.integrity_two_n <= 1'b1;
    frm(2, DW);
    $display("fault handling done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst();
    t_regs();
    t_res16();
    t_chain();
    t_fault();
    close_out();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    close_out();
  end
endmodule
bind sensor_slot_tx slot_tx_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .cmd(cmd), .fault_pin(fault_pin), .tx_valid(tx_valid),
  .tx_fixed_fmt(tx_fixed_fmt), .sync_pulldown_en(sync_pulldown_en), .bus_switch_closed(bus_switch_closed));
